// >>> logic/pbc_phy_regs.v
// Indexed PHY register set centred on the basic control register.
// Assumes the MAC management logic issues single-cycle indexed requests on
// the same clock, and that PHY core status inputs are synchronous to it.
`timescale 1ns/1ps
`include "pbc_regs.vh"

module pbc_phy_regs #(
	parameter SRST_CYCLES = `PBC_SRST_CYCLES,
	parameter [15:0] ID_HIGH_RESET = `PBC_ID_HIGH_RESET,
	parameter [15:0] ID_LOW_RESET = `PBC_ID_LOW_RESET
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// Indexed access port from the MAC management logic
	input wire acc_req_i,
	input wire acc_write_i,
	input wire [`PBC_IDX_W-1:0] acc_index_i,
	input wire [15:0] acc_wdata_i,
	output reg acc_ack_o,
	output reg [15:0] acc_rdata_o,
	// Status from the PHY core
	input wire an_complete_i,
	input wire an_speed_100_i,
	input wire an_full_duplex_i,
	input wire link_up_i,
	input wire remote_fault_i,
	input wire jabber_i,
	input wire [15:0] partner_ability_i,
	input wire [15:0] expansion_i,
	input wire [15:0] int_source_i,
	input wire symbol_error_i,
	// Controls to the PHY core
	output reg core_reset_o,
	output reg loopback_o,
	output reg speed_100_o,
	output reg full_duplex_o,
	output reg an_enable_o,
	output reg an_restart_o,
	output reg power_down_o,
	output reg col_test_o,
	output reg [15:0] advertise_o
);

	// ------------------------------------------------------------------------
	// Index decode helpers
	// ------------------------------------------------------------------------

	// Slot of the plain storage bank, valid only where is_bank is true
	function [2:0] bank_slot;
		input [`PBC_IDX_W-1:0] idx;
		begin
			if (idx == `PBC_IDX_ENERGY_DETECT_POWERDOWN_XOVER) begin
				bank_slot = 3'h0;
			end else if (idx == `PBC_IDX_MODE_CTRL) begin
				bank_slot = 3'h1;
			end else if (idx == `PBC_IDX_SPECIAL_MODES) begin
				bank_slot = 3'h2;
			end else if (idx == `PBC_IDX_SPECIAL_IND) begin
				bank_slot = 3'h3;
			end else if (idx == `PBC_IDX_INT_MASK) begin
				bank_slot = 3'h4;
			end else begin
				bank_slot = 3'h5;
			end
		end
	endfunction

	// True for indexes held in the plain storage bank
	function is_bank;
		input [`PBC_IDX_W-1:0] idx;
		begin
			is_bank = (idx == `PBC_IDX_ENERGY_DETECT_POWERDOWN_XOVER) || (idx == `PBC_IDX_MODE_CTRL) ||
				(idx == `PBC_IDX_SPECIAL_MODES) || (idx == `PBC_IDX_SPECIAL_IND) ||
				(idx == `PBC_IDX_INT_MASK) || (idx == `PBC_IDX_PHY_SPECIAL);
		end
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	reg [15:0] control;
	reg [15:0] id_high;
	reg [15:0] id_low;
	reg [15:0] advertise;
	reg [15:0] symbol_count;
	reg [15:0] bank [0:5];
	reg link_latched;
	reg jabber_latched;
	reg fault_latched;
	reg an_enable_d;
	reg [15:0] next_rdata;
	wire wr;
	wire rd;
	wire wr_control;
	wire srst_start;
	wire srst_busy;
	wire srst_done;
	wire read_status;
	wire [15:0] status_word;
	integer i;

	// Access strobes, all addressing is by index only
	assign wr = acc_req_i & acc_write_i;
	assign rd = acc_req_i & ~acc_write_i;
	assign wr_control = wr && (acc_index_i == `PBC_IDX_BASIC_CONTROL);
	assign srst_start = wr_control & acc_wdata_i[`PBC_BC_SOFT_RESET] & ~srst_busy;
	assign read_status = rd && (acc_index_i == `PBC_IDX_BASIC_STATUS);

	// ------------------------------------------------------------------------
	// Soft reset sequencer
	// ------------------------------------------------------------------------
	pbc_soft_reset_seq #(
		.CYCLES(SRST_CYCLES)
	) u_srst (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(srst_start),
		.busy_o(srst_busy),
		.done_o(srst_done)
	);

	// ------------------------------------------------------------------------
	// Basic control register
	// ------------------------------------------------------------------------

	// Stored fields; a soft reset returns them to defaults and normal mode
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			control <= `PBC_BC_RESET;
		end else if (srst_start || srst_busy || srst_done) begin
			// Defaults from the start edge on, so a read during the reset never shows old modes
			control <= `PBC_BC_RESET;
		end else if (wr_control && !acc_wdata_i[`PBC_BC_SOFT_RESET]) begin
			// Reserved bits dropped; a reset write carries nothing else
			control <= acc_wdata_i & `PBC_BC_STORE_MASK;
		end
	end

	// Restart pulse from the self-clearing bit, or from enabling negotiation
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			an_restart_o <= 1'b0;
			an_enable_d <= 1'b1;
		end else begin
			an_enable_d <= control[`PBC_BC_AN_ENABLE];
			an_restart_o <= (wr_control && !srst_busy && !acc_wdata_i[`PBC_BC_SOFT_RESET] &&
				acc_wdata_i[`PBC_BC_AN_RESTART]) ||
				(control[`PBC_BC_AN_ENABLE] && !an_enable_d);
		end
	end

	// Registered controls to the PHY core
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			core_reset_o <= 1'b0;
			loopback_o <= 1'b0;
			speed_100_o <= 1'b1;
			full_duplex_o <= 1'b0;
			an_enable_o <= 1'b1;
			power_down_o <= 1'b0;
			col_test_o <= 1'b0;
			advertise_o <= `PBC_ADV_RESET;
		end else begin
			core_reset_o <= srst_busy;
			loopback_o <= control[`PBC_BC_LOOPBACK];
			// Negotiated result overrides the manual speed and duplex
			if (control[`PBC_BC_AN_ENABLE]) begin
				speed_100_o <= an_speed_100_i;
				full_duplex_o <= an_full_duplex_i;
			end else begin
				speed_100_o <= control[`PBC_BC_SPEED_100];
				full_duplex_o <= control[`PBC_BC_FULL_DUPLEX];
			end
			an_enable_o <= control[`PBC_BC_AN_ENABLE];
			// Order against the enable bit is left to software
			power_down_o <= control[`PBC_BC_POWER_DOWN];
			col_test_o <= control[`PBC_BC_COL_TEST];
			advertise_o <= advertise;
		end
	end

	// ------------------------------------------------------------------------
	// Basic status latches
	// ------------------------------------------------------------------------

	// Link latches low, jabber and fault latch high; an event beats the read
	always @(posedge clk_i) begin
		if (!reset_n_i || srst_busy) begin
			link_latched <= 1'b0;
			jabber_latched <= 1'b0;
			fault_latched <= 1'b0;
		end else begin
			link_latched <= read_status ? link_up_i : (link_latched & link_up_i);
			jabber_latched <= jabber_i | (jabber_latched & ~read_status);
			fault_latched <= remote_fault_i | (fault_latched & ~read_status);
		end
	end

	assign status_word = `PBC_BS_FIXED |
		({15'h0000, an_complete_i & control[`PBC_BC_AN_ENABLE]} << `PBC_BS_AN_COMPLETE) |
		({15'h0000, fault_latched} << `PBC_BS_REMOTE_FAULT) |
		({15'h0000, link_latched} << `PBC_BS_LINK_UP) |
		({15'h0000, jabber_latched} << `PBC_BS_JABBER);

	// ------------------------------------------------------------------------
	// Identifier, advertisement and symbol error counter
	// ------------------------------------------------------------------------

	// Identifiers are soft-reset-immune; only the pin reset restores them
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			id_high <= ID_HIGH_RESET;
			id_low <= ID_LOW_RESET;
		end else if (wr && acc_index_i == `PBC_IDX_ID_HIGH) begin
			id_high <= acc_wdata_i;
		end else if (wr && acc_index_i == `PBC_IDX_ID_LOW) begin
			id_low <= acc_wdata_i;
		end
	end

	// Advertisement follows soft reset; selector field is fixed
	always @(posedge clk_i) begin
		if (!reset_n_i || srst_busy) begin
			advertise <= `PBC_ADV_RESET;
		end else if (wr && acc_index_i == `PBC_IDX_AN_ADVERTISE) begin
			advertise <= (acc_wdata_i & `PBC_ADV_WRITE_MASK) | (`PBC_ADV_RESET & ~`PBC_ADV_WRITE_MASK);
		end
	end

	// Saturating count of symbol errors, cleared by any reset
	always @(posedge clk_i) begin
		if (!reset_n_i || srst_busy) begin
			symbol_count <= 16'h0000;
		end else if (symbol_error_i && symbol_count != 16'hffff) begin
			symbol_count <= symbol_count + 16'h0001;
		end
	end

	// ------------------------------------------------------------------------
	// Plain storage bank
	// ------------------------------------------------------------------------

	// Soft-reset-immune words; cleared only by the pin reset
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (i = 0; i < 6; i = i + 1) begin
				bank[i] <= 16'h0000;
			end
		end else if (wr && is_bank(acc_index_i)) begin
			bank[bank_slot(acc_index_i)] <= acc_wdata_i;
		end
	end

	// ------------------------------------------------------------------------
	// Read mux and answer
	// ------------------------------------------------------------------------

	// Select the word for the requested index
	always @* begin
		next_rdata = 16'h0000;
		if (acc_index_i == `PBC_IDX_BASIC_CONTROL) begin
			// Bit 15 reads one while the soft reset runs
			next_rdata = control | ({15'h0000, srst_busy} << `PBC_BC_SOFT_RESET);
		end else if (acc_index_i == `PBC_IDX_BASIC_STATUS) begin
			next_rdata = status_word;
		end else if (acc_index_i == `PBC_IDX_ID_HIGH) begin
			next_rdata = id_high;
		end else if (acc_index_i == `PBC_IDX_ID_LOW) begin
			next_rdata = id_low;
		end else if (acc_index_i == `PBC_IDX_AN_ADVERTISE) begin
			next_rdata = advertise;
		end else if (acc_index_i == `PBC_IDX_AN_PARTNER) begin
			next_rdata = partner_ability_i;
		end else if (acc_index_i == `PBC_IDX_AUTONEG_EXPANSION) begin
			next_rdata = expansion_i;
		end else if (acc_index_i == `PBC_IDX_SYMBOL_ERR) begin
			next_rdata = symbol_count;
		end else if (acc_index_i == `PBC_IDX_INT_SOURCE) begin
			next_rdata = int_source_i;
		end else if (is_bank(acc_index_i)) begin
			next_rdata = bank[bank_slot(acc_index_i)];
		end else begin
			next_rdata = 16'h0000;
		end
	end

	// Answer one cycle after every request; read data held until next read
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			acc_ack_o <= 1'b0;
			acc_rdata_o <= 16'h0000;
		end else begin
			acc_ack_o <= acc_req_i;
			if (rd) begin
				acc_rdata_o <= next_rdata;
			end
		end
	end

endmodule

// >>> logic/pbc_regs.vh
// Constants for the indexed PHY register set: indexes, field positions,
// reset values, masks and timing counts.
// Assumes a 50 MHz system clock and a 5-bit register index.
`ifndef PBC_REGS_VH
`define PBC_REGS_VH

// ----------------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------------
`define PBC_IDX_W 5
`define PBC_IDX_BASIC_CONTROL 5'h00
`define PBC_IDX_BASIC_STATUS 5'h01
`define PBC_IDX_ID_HIGH 5'h02
`define PBC_IDX_ID_LOW 5'h03
`define PBC_IDX_AN_ADVERTISE 5'h04
`define PBC_IDX_AN_PARTNER 5'h05
`define PBC_IDX_AUTONEG_EXPANSION 5'h06
`define PBC_IDX_ENERGY_DETECT_POWERDOWN_XOVER 5'h10
`define PBC_IDX_MODE_CTRL 5'h11
`define PBC_IDX_SPECIAL_MODES 5'h12
`define PBC_IDX_SYMBOL_ERR 5'h1a
`define PBC_IDX_SPECIAL_IND 5'h1b
`define PBC_IDX_INT_SOURCE 5'h1d
`define PBC_IDX_INT_MASK 5'h1e
`define PBC_IDX_PHY_SPECIAL 5'h1f

// ----------------------------------------------------------------------------
// Basic control fields
// ----------------------------------------------------------------------------
`define PBC_BC_SOFT_RESET 15
`define PBC_BC_LOOPBACK 14
`define PBC_BC_SPEED_100 13
`define PBC_BC_AN_ENABLE 12
`define PBC_BC_POWER_DOWN 11
`define PBC_BC_AN_RESTART 9
`define PBC_BC_FULL_DUPLEX 8
`define PBC_BC_COL_TEST 7
`define PBC_BC_RESET 16'h3000
`define PBC_BC_STORE_MASK 16'h7980

// ----------------------------------------------------------------------------
// Basic status fields
// ----------------------------------------------------------------------------
`define PBC_BS_AN_COMPLETE 5
`define PBC_BS_REMOTE_FAULT 4
`define PBC_BS_LINK_UP 2
`define PBC_BS_JABBER 1
`define PBC_BS_FIXED 16'h7809

// ----------------------------------------------------------------------------
// Advertisement and identifier values
// ----------------------------------------------------------------------------
`define PBC_ADV_RESET 16'h01e1
`define PBC_ADV_WRITE_MASK 16'h2de0
// Identifier defaults are arbitrary neutral values
`define PBC_ID_HIGH_RESET 16'h1234
`define PBC_ID_LOW_RESET 16'h5670

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PBC_CLK_MHZ 50
`define PBC_SRST_TIME_NS 100000
`define PBC_SRST_CYCLES ((`PBC_SRST_TIME_NS * `PBC_CLK_MHZ + 999) / 1000)
`define PBC_SRST_CNT_W 16

`endif

// >>> logic/pbc_soft_reset_seq.v
// Soft reset sequencer: holds the PHY core in reset for a fixed number of
// cycles after a start pulse, then reports completion.
// Assumes start_i is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "pbc_regs.vh"

module pbc_soft_reset_seq #(
	parameter CYCLES = `PBC_SRST_CYCLES
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// Control
	input wire start_i,
	// Status
	output wire busy_o,
	output reg done_o
);

	reg [`PBC_SRST_CNT_W-1:0] count;
	reg busy;
	wire [`PBC_SRST_CNT_W-1:0] last_count;

	assign last_count = CYCLES[`PBC_SRST_CNT_W-1:0] - 16'h0001;
	assign busy_o = busy;

	// Count out the reset interval, restart ignored while busy
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			busy <= 1'b0;
			count <= 16'h0000;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!busy) begin
				if (start_i) begin
					busy <= 1'b1;
					count <= 16'h0000;
				end
			end else if (count == last_count) begin
				busy <= 1'b0; // Bit clears itself here
				done_o <= 1'b1;
			end else begin
				count <= count + 16'h0001;
			end
		end
	end

endmodule

// >>> sim/pbc_phy_regs_asserts.sv
// Checker for the indexed PHY register set: access answers and core controls.
// Assumes it is bound to pbc_phy_regs with a matching SRST_CYCLES.
`timescale 1ns/1ps
module pbc_phy_regs_asserts #(
	parameter SRST_CYCLES = 8
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// Access port
	input wire acc_req_i,
	input wire acc_write_i,
	input wire [4:0] acc_index_i,
	input wire [15:0] acc_wdata_i,
	input wire acc_ack_o,
	input wire [15:0] acc_rdata_o,
	// Core side
	input wire an_complete_i,
	input wire an_speed_100_i,
	input wire an_full_duplex_i,
	input wire core_reset_o,
	input wire loopback_o,
	input wire speed_100_o,
	input wire full_duplex_o,
	input wire an_enable_o,
	input wire an_restart_o,
	input wire power_down_o,
	input wire col_test_o
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire rd = acc_req_i && !acc_write_i;
	wire wr0 = acc_req_i && acc_write_i && acc_index_i == 5'h00;
	int hi_cnt = 0;
	// Length of the current core reset pulse
	always @(posedge clk_i) begin
		if (!reset_n_i || !core_reset_o)
			hi_cnt <= 0;
		else
			hi_cnt <= hi_cnt + 1;
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	ack_timing_a: assert property (acc_req_i |=> acc_ack_o) else $error("no ack after request");
	ack_idle_a: assert property (!acc_req_i |=> !acc_ack_o) else $error("ack without request");
	unimpl_read_a: assert property (rd && !(acc_index_i inside {[5'h00:5'h06], [5'h10:5'h12], 5'h1a, 5'h1b,
		[5'h1d:5'h1f]}) |=> acc_rdata_o == 16'h0000) else $error("unimplemented index read nonzero");
	srst_start_a: assert property (wr0 && acc_wdata_i[15] && !core_reset_o |-> ##2 core_reset_o)
		else $error("soft reset did not start");
	srst_len_a: assert property ($fell(core_reset_o) |-> hi_cnt == SRST_CYCLES)
		else $error("soft reset length wrong");
	srst_normal_a: assert property ($fell(core_reset_o) |-> !loopback_o && !power_down_o && !col_test_o &&
		an_enable_o) else $error("not normal mode after soft reset");
	restart_pulse_a: assert property (wr0 && acc_wdata_i[9] && !acc_wdata_i[15] && !core_reset_o
		|=> an_restart_o) else $error("restart pulse missing");
	speed_mux_a: assert property (an_enable_o && $past(reset_n_i, 2) && !core_reset_o && !$past(core_reset_o)
		|-> speed_100_o == $past(an_speed_100_i) && full_duplex_o == $past(an_full_duplex_i))
		else $error("negotiated result not applied");
	status_an_a: assert property (rd && acc_index_i == 5'h01 && !core_reset_o
		|=> acc_rdata_o[5] == ($past(an_complete_i) && an_enable_o)) else $error("status complete bit wrong");
	reserved_ctrl_a: assert property (rd && acc_index_i == 5'h00 |=> (acc_rdata_o & 16'h067f) == 16'h0000)
		else $error("reserved control bits nonzero");
	// Main scenarios
	cover property ($rose(core_reset_o));
	cover property (an_restart_o);
	cover property (rd && acc_index_i == 5'h07);
endmodule

// >>> sim/pbc_mac_model.sv
// Management access model: issues single indexed register operations.
// Assumes the register set answers one cycle after the request edge.
`timescale 1ns/1ps
module pbc_mac_model (
	// Clock
	input wire clk_i,
	// Access port
	output logic acc_req_o,
	output logic acc_write_o,
	output logic [4:0] acc_index_o,
	output logic [15:0] acc_wdata_o,
	input wire acc_ack_i,
	input wire [15:0] acc_rdata_i
);
	// Idle levels
	initial begin
		acc_req_o = 1'b0;
		acc_write_o = 1'b0;
		acc_index_o = 5'h00;
		acc_wdata_o = 16'h0000;
	end
	// One access by index, one clean cycle before each request
	task automatic access(input logic w, input logic [4:0] idx, input logic [15:0] wd,
		output logic [15:0] rd, output logic ok);
		@(posedge clk_i);
		#1;
		acc_req_o = 1'b1;
		acc_write_o = w;
		acc_index_o = idx;
		acc_wdata_o = (w && idx == 5'h00 && wd[15]) ? 16'h8000 : wd;
		@(posedge clk_i);
		#1;
		acc_req_o = 1'b0;
		ok = acc_ack_i;
		rd = acc_rdata_i;
		// Released lines show no stale value
		acc_index_o = ~idx;
		acc_wdata_o = ~acc_wdata_o;
	endtask
endmodule

// >>> sim/pbc_phy_regs_tb_top.sv
// Top bench for the indexed PHY register set with a management access model.
// Assumes a 50 MHz clock and a soft reset shortened to eight cycles.
`timescale 1ns/1ps
module pbc_phy_regs_tb_top;
	localparam SRST = 8;
	typedef struct {logic w; logic [4:0] i; logic [15:0] d; logic [15:0] e; logic [5:0] o;} pbc_row_t;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk_i = 0, reset_n_i = 0, an_complete_i = 0, an_speed_100_i = 0, an_full_duplex_i = 1;
	logic link_up_i = 0, remote_fault_i = 0, jabber_i = 0, symbol_error_i = 0, ok;
	logic [15:0] partner_ability_i = 16'h41e1, expansion_i = 16'h0005, int_source_i = 16'hc3c3, rd;
	wire acc_req_i, acc_write_i, acc_ack_o, core_reset_o, loopback_o, speed_100_o, full_duplex_o;
	wire an_enable_o, an_restart_o, power_down_o, col_test_o;
	wire [4:0] acc_index_i;
	wire [15:0] acc_wdata_i, acc_rdata_o, advertise_o;
	wire [5:0] outs = {loopback_o, speed_100_o, full_duplex_o, an_enable_o, power_down_o, col_test_o};
	int error_cnt = 0, check_count = 0, cyc = 0;
	pbc_row_t rows[18] = '{'{0, 5'h00, 16'h0, 16'h3000, 6'h0c}, '{0, 5'h02, 16'h0, 16'h1234, 6'h0c},
		'{0, 5'h03, 16'h0, 16'h5670, 6'h0c}, '{0, 5'h04, 16'h0, 16'h01e1, 6'h0c},
		'{0, 5'h01, 16'h0, 16'h7809, 6'h0c}, '{0, 5'h05, 16'h0, 16'h41e1, 6'h0c},
		'{0, 5'h06, 16'h0, 16'h0005, 6'h0c}, '{0, 5'h1d, 16'h0, 16'hc3c3, 6'h0c},
		'{1, 5'h00, 16'h0000, 16'h0000, 6'h00}, '{1, 5'h00, 16'h6fff, 16'h6980, 6'h3b},
		'{1, 5'h04, 16'hffff, 16'h2de1, 6'h3b}, '{1, 5'h01, 16'hffff, 16'h7809, 6'h3b},
		'{1, 5'h05, 16'hffff, 16'h41e1, 6'h3b}, '{1, 5'h10, 16'ha5a5, 16'ha5a5, 6'h3b},
		'{1, 5'h1f, 16'h5a5a, 16'h5a5a, 6'h3b}, '{1, 5'h07, 16'hffff, 16'h0000, 6'h3b},
		'{1, 5'h14, 16'hffff, 16'h0000, 6'h3b}, '{1, 5'h00, 16'h1000, 16'h1000, 6'h0c}};
	// ------------------------------------------------------------
	// Design and far side
	// ------------------------------------------------------------
	pbc_phy_regs #(.SRST_CYCLES(SRST)) i_dut (.clk_i, .reset_n_i, .acc_req_i, .acc_write_i, .acc_index_i,
		.acc_wdata_i, .acc_ack_o, .acc_rdata_o, .an_complete_i, .an_speed_100_i, .an_full_duplex_i, .link_up_i,
		.remote_fault_i, .jabber_i, .partner_ability_i, .expansion_i, .int_source_i, .symbol_error_i,
		.core_reset_o, .loopback_o, .speed_100_o, .full_duplex_o, .an_enable_o, .an_restart_o, .power_down_o,
		.col_test_o, .advertise_o);
	pbc_mac_model i_mac (.clk_i, .acc_req_o(acc_req_i), .acc_write_o(acc_write_i), .acc_index_o(acc_index_i),
		.acc_wdata_o(acc_wdata_i), .acc_ack_i(acc_ack_o), .acc_rdata_i(acc_rdata_o));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Access with answer check
	task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d);
		i_mac.access(w, i, d, rd, ok);
		chk({15'h0, ok}, 16'h0001);
	endtask
	task automatic rdchk(input logic [4:0] i, input logic [15:0] e);
		acc(1'b0, i, 16'h0);
		chk(rd, e);
	endtask
	// Clock and hang limit
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			end_sim();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		#1 reset_n_i = 1;
		// Table of accesses; negotiation is cleared in a write before power down
		foreach (rows[k]) begin
			if (rows[k].w)
				acc(1'b1, rows[k].i, rows[k].d);
			rdchk(rows[k].i, rows[k].e);
			chk({10'h0, outs}, {10'h0, rows[k].o});
		end
		// Restart pulse and self-clear
		acc(1'b1, 5'h00, 16'h1200);
		chk({15'h0, an_restart_o}, 16'h0001);
		rdchk(5'h00, 16'h1000);
		chk(advertise_o, 16'h2de1);
		// Core events: symbol error, fault and jabber pulses, link up, negotiation done at 100
		@(posedge clk_i);
		#1 symbol_error_i = 1;
		remote_fault_i = 1;
		jabber_i = 1;
		link_up_i = 1;
		an_complete_i = 1;
		an_speed_100_i = 1;
		@(posedge clk_i);
		#1 symbol_error_i = 0;
		remote_fault_i = 0;
		jabber_i = 0;
		rdchk(5'h1a, 16'h0001);
		// First read shows latched events, second shows the cleared latches and the link
		rdchk(5'h01, 16'h783b);
		rdchk(5'h01, 16'h782d);
		// Soft reset keeps immune storage and returns to defaults
		acc(1'b1, 5'h00, 16'h8000);
		rdchk(5'h00, 16'hb000);
		for (int n = 0; n < 40 && core_reset_o !== 1'b0; n++) begin
			@(posedge clk_i);
			#1;
		end
		rdchk(5'h00, 16'h3000);
		chk({10'h0, outs}, 16'h001c);
		chk(advertise_o, 16'h01e1);
		rdchk(5'h10, 16'ha5a5);
		// Hard reset clears immune storage too
		reset_n_i = 0;
		repeat (3) @(posedge clk_i);
		#1 reset_n_i = 1;
		rdchk(5'h10, 16'h0000);
		rdchk(5'h00, 16'h3000);
		end_sim();
	end
endmodule

bind pbc_phy_regs pbc_phy_regs_asserts #(.SRST_CYCLES(SRST_CYCLES)) i_chk (.clk_i, .reset_n_i, .acc_req_i,
	.acc_write_i, .acc_index_i, .acc_wdata_i, .acc_ack_o, .acc_rdata_o, .an_complete_i, .an_speed_100_i,
	.an_full_duplex_i, .core_reset_o, .loopback_o, .speed_100_o, .full_duplex_o, .an_enable_o, .an_restart_o,
	.power_down_o, .col_test_o);
